// >>> logic/fpep_top.sv
// module: flash program/erase protection with Avalon-MM register slave
// ==================================================================
// Overview of operation
// - write gate low clears registers, blocks everything
// - any reset or standby clears registers, locks
// - fault while armed sets error flag
// - error keeps registers, aborts program or erase
// - in error no program, erase or block select
// - in error verify bits still work
// - only hard init or hardware standby clear error
// - in error registers writable, software standby clears
// - error only reports status, processor unaffected
// - arm bits set block the nmi
// - boot mode blocks nmi until boot branch
// - error state also blocks the nmi
// - reads while armed may return garbage
`default_nettype none
module fpep_top
	import fpep_pkg::*;
#(
	parameter int BLOCKS = 8
) (
	// clock, reset, clock enable
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic ce,
	// Avalon-MM slave
	input wire logic [FPEP_AW-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// device pins and system conditions
	input wire logic flash_write_gate_pin,
	input wire logic hard_init_pin,
	input wire logic wdt_reset,
	input wire logic sw_standby,
	input wire logic hw_standby,
	input wire logic algo_fault,
	input wire logic boot_mode,
	input wire logic boot_branch,
	// nmi path
	input wire logic nmi_in,
	output logic nmi_out,
	// flash array controls
	output logic program_mode,
	output logic erase_mode,
	output logic verify_mode,
	output logic [BLOCKS-1:0] erase_block_en,
	output logic flash_read_undef,
	// interrupt
	output logic irq
);
	// ==================================================================
	// init conditions
	logic init_all;
	logic init_regs;
	// hard init is sampled per cycle; the pulse must last at least one edge
	assign init_all = !hard_init_pin || hw_standby;
	// software standby and a low write gate reset registers only; the watchdog also restarts the boot window
	assign init_regs = init_all || wdt_reset || sw_standby || !flash_write_gate_pin;

	// ==================================================================
	// bus handshake: one wait cycle, then a single accept cycle
	logic wait_ff;
	logic nxt_wait;
	logic [31:0] rdata_ff;
	logic [31:0] nxt_rdata;
	logic take_rd;
	logic take_wr;
	logic capture;
	logic [31:0] rd_mux;

	assign capture = (avs_read || avs_write) && wait_ff;
	assign take_rd = avs_read && !wait_ff;
	assign take_wr = avs_write && !wait_ff && avs_byteenable[0];

	// ==================================================================
	// registers and protection state
	fpep_state_e state_ff;
	fpep_state_e nxt_state;
	logic [FPEP_CTRL_W-1:0] ctrl_ff;
	logic [FPEP_CTRL_W-1:0] nxt_ctrl;
	logic [BLOCKS-1:0] wipe_ff;
	logic [BLOCKS-1:0] nxt_wipe;
	logic [FPEP_EV_W-1:0] mask_ff;
	logic [FPEP_EV_W-1:0] nxt_mask;
	logic boot_done_ff;
	logic nxt_boot_done;
	logic armed;
	logic err_now;
	logic forced;
	logic [FPEP_EV_W-1:0] ev_set;
	logic [FPEP_EV_W-1:0] ev_clr;
	logic [FPEP_EV_W-1:0] ev_q;

	assign armed = ctrl_ff[FPEP_B_WRITE_ARM] || ctrl_ff[FPEP_B_BLANK_ARM];
	// fault only counts while an operation is armed
	assign err_now = armed && algo_fault && (state_ff == FPEP_ST_OPEN);
	// armed registers wiped by a protection condition
	assign forced = armed && init_regs;

	// state transitions; the error state survives all but a hard init or hardware standby
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			FPEP_ST_LOCKED: begin
				if (!init_regs) begin
					nxt_state = FPEP_ST_OPEN;
				end
			end
			FPEP_ST_OPEN: begin
				if (init_regs) begin
					nxt_state = FPEP_ST_LOCKED;
				end else if (err_now) begin
					nxt_state = FPEP_ST_ERROR;
				end
			end
			FPEP_ST_ERROR: begin
				if (init_all) begin
					nxt_state = FPEP_ST_LOCKED;
				end
			end
			default: begin
				nxt_state = FPEP_ST_LOCKED;
			end
		endcase
	end

	// control and block select; entering error leaves both untouched
	always_comb begin
		nxt_ctrl = ctrl_ff;
		nxt_wipe = wipe_ff;
		nxt_mask = mask_ff;
		nxt_boot_done = boot_done_ff;
		if (init_regs) begin
			nxt_ctrl = FPEP_CTRL_RST;
			nxt_wipe = BLOCKS'(FPEP_WIPE_RST);
		end else if (take_wr && avs_address == FPEP_OFS_CTRL) begin
			nxt_ctrl = avs_writedata[FPEP_CTRL_W-1:0];
		end else if (take_wr && avs_address == FPEP_OFS_WIPE) begin
			nxt_wipe = avs_writedata[BLOCKS-1:0];
		end
		if (take_wr && avs_address == FPEP_OFS_IRQM) begin
			nxt_mask = avs_writedata[FPEP_EV_W-1:0];
		end
		// boot window ends at the first branch into the ram boot area
		if (init_all || wdt_reset) begin
			nxt_boot_done = 1'b0;
		end else if (boot_branch) begin
			nxt_boot_done = 1'b1;
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			state_ff <= FPEP_ST_LOCKED;
			ctrl_ff <= FPEP_CTRL_RST;
			wipe_ff <= BLOCKS'(FPEP_WIPE_RST);
			mask_ff <= FPEP_EV_RST;
			boot_done_ff <= 1'b0;
		end else if (ce) begin
			state_ff <= nxt_state;
			ctrl_ff <= nxt_ctrl;
			wipe_ff <= nxt_wipe;
			mask_ff <= nxt_mask;
			boot_done_ff <= nxt_boot_done;
		end
	end

	// ==================================================================
	// flash array controls, all registered
	logic prog_ff;
	logic nxt_prog;
	logic erase_ff;
	logic nxt_erase;
	logic verify_ff;
	logic nxt_verify;
	logic [BLOCKS-1:0] blk_ff;
	logic [BLOCKS-1:0] nxt_blk;
	logic undef_ff;
	logic nxt_undef;
	logic nmi_ff;
	logic nxt_nmi;
	logic nmi_block;
	logic irq_ff;
	logic nxt_irq;

	// nmi is held off while armed, in error, or in boot mode before the boot branch
	assign nmi_block = armed
		|| (state_ff == FPEP_ST_ERROR)
		|| (boot_mode && !boot_done_ff);

	// program and erase only in the open state; error aborts at once
	always_comb begin
		nxt_prog = ctrl_ff[FPEP_B_WRITE_ARM] && (nxt_state == FPEP_ST_OPEN);
		nxt_erase = ctrl_ff[FPEP_B_BLANK_ARM] && (nxt_state == FPEP_ST_OPEN);
		// verify is refused only when the registers are being wiped
		nxt_verify = (ctrl_ff[FPEP_B_WRITE_CHECK] || ctrl_ff[FPEP_B_BLANK_CHECK])
			&& !init_regs;
		nxt_blk = nxt_erase ? wipe_ff : '0;
		// array data is not trusted while an operation is armed
		nxt_undef = armed;
		nxt_nmi = nmi_in && !nmi_block;
		// error entry drives no halt or exception to the processor
		nxt_irq = |(ev_q & mask_ff);
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			prog_ff <= 1'b0;
			erase_ff <= 1'b0;
			verify_ff <= 1'b0;
			blk_ff <= '0;
			undef_ff <= 1'b0;
			nmi_ff <= 1'b0;
			irq_ff <= 1'b0;
		end else if (ce) begin
			prog_ff <= nxt_prog;
			erase_ff <= nxt_erase;
			verify_ff <= nxt_verify;
			blk_ff <= nxt_blk;
			undef_ff <= nxt_undef;
			nmi_ff <= nxt_nmi;
			irq_ff <= nxt_irq;
		end
	end

	// ==================================================================
	// event status; a read clears only the bits it returned, so an event
	// landing between capture and accept stays pending
	assign ev_set[FPEP_EV_ERROR] = err_now;
	assign ev_set[FPEP_EV_FORCED] = forced;
	assign ev_clr = (take_rd && avs_address == FPEP_OFS_IRQS) ?
		rdata_ff[FPEP_EV_W-1:0] : '0;

	fpep_sticky #(
		.W(FPEP_EV_W)
	) u_events (
		.mclk(mclk),
		.reset_n(reset_n),
		.ce(ce),
		.set(ev_set),
		.clr(ev_clr),
		.q(ev_q)
	);

	// ==================================================================
	// read mux; unmapped offsets read zero, writes to them are dropped
	logic [FPEP_STAT_W-1:0] stat;
	assign stat[FPEP_S_ERROR] = (state_ff == FPEP_ST_ERROR);
	assign stat[FPEP_S_LOCKED] = (state_ff == FPEP_ST_LOCKED);
	assign stat[FPEP_S_PROG] = prog_ff;
	assign stat[FPEP_S_ERASE] = erase_ff;
	assign stat[FPEP_S_VERIFY] = verify_ff;
	assign stat[FPEP_S_NMI_BLOCK] = nmi_block;

	always_comb begin
		rd_mux = '0;
		case (avs_address)
			FPEP_OFS_CTRL: rd_mux[FPEP_CTRL_W-1:0] = ctrl_ff;
			FPEP_OFS_WIPE: rd_mux[BLOCKS-1:0] = wipe_ff;
			FPEP_OFS_STAT: rd_mux[FPEP_STAT_W-1:0] = stat;
			FPEP_OFS_IRQS: rd_mux[FPEP_EV_W-1:0] = ev_q;
			FPEP_OFS_IRQM: rd_mux[FPEP_EV_W-1:0] = mask_ff;
			default: rd_mux = '0;
		endcase
	end

	// waitrequest drops for exactly the cycle after a request is seen
	always_comb begin
		nxt_wait = !capture;
		nxt_rdata = rdata_ff;
		if (capture && avs_read) begin
			nxt_rdata = rd_mux;
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			wait_ff <= 1'b1;
			rdata_ff <= '0;
		end else if (ce) begin
			wait_ff <= nxt_wait;
			rdata_ff <= nxt_rdata;
		end
	end

	// ==================================================================
	// outputs straight from flip-flops
	assign avs_readdata = rdata_ff;
	assign avs_waitrequest = wait_ff;
	assign program_mode = prog_ff;
	assign erase_mode = erase_ff;
	assign verify_mode = verify_ff;
	assign erase_block_en = blk_ff;
	assign flash_read_undef = undef_ff;
	assign nmi_out = nmi_ff;
	assign irq = irq_ff;
endmodule // fpep_top
`default_nettype wire

// >>> logic/fpep_pkg.sv
// package: register map, field positions and protection states of the flash protection block
`default_nettype none
package fpep_pkg;
	// ==================================================================
	// register byte offsets (one aligned word each)
	localparam int FPEP_AW = 5;
	localparam logic [FPEP_AW-1:0] FPEP_OFS_CTRL = 5'h00; // flash_control_reg
	localparam logic [FPEP_AW-1:0] FPEP_OFS_WIPE = 5'h04; // block_wipe_select_reg
	localparam logic [FPEP_AW-1:0] FPEP_OFS_STAT = 5'h08; // flash_status_reg, read only
	localparam logic [FPEP_AW-1:0] FPEP_OFS_IRQS = 5'h0c; // event status, read clears
	localparam logic [FPEP_AW-1:0] FPEP_OFS_IRQM = 5'h10; // event mask
	// ==================================================================
	// flash_control_reg fields
	localparam int FPEP_CTRL_W = 4;
	localparam int FPEP_B_WRITE_ARM = 0;
	localparam int FPEP_B_BLANK_ARM = 1;
	localparam int FPEP_B_WRITE_CHECK = 2;
	localparam int FPEP_B_BLANK_CHECK = 3;
	localparam logic [FPEP_CTRL_W-1:0] FPEP_CTRL_RST = 4'h0;
	localparam logic [7:0] FPEP_WIPE_RST = 8'h00;
	// ==================================================================
	// flash_status_reg fields
	localparam int FPEP_STAT_W = 6;
	localparam int FPEP_S_ERROR = 0;
	localparam int FPEP_S_LOCKED = 1;
	localparam int FPEP_S_PROG = 2;
	localparam int FPEP_S_ERASE = 3;
	localparam int FPEP_S_VERIFY = 4;
	localparam int FPEP_S_NMI_BLOCK = 5;
	// ==================================================================
	// event bits shared by status and mask
	localparam int FPEP_EV_W = 2;
	localparam int FPEP_EV_ERROR = 0;
	localparam int FPEP_EV_FORCED = 1;
	localparam logic [FPEP_EV_W-1:0] FPEP_EV_RST = 2'h0;
	// ==================================================================
	// protection state, one-hot
	typedef enum logic [2:0] {
		FPEP_ST_LOCKED = 3'b001,
		FPEP_ST_OPEN = 3'b010,
		FPEP_ST_ERROR = 3'b100
	} fpep_state_e;
endpackage : fpep_pkg
`default_nettype wire

// >>> logic/fpep_sticky.sv
// module: bank of sticky event bits, set wins over clear
`default_nettype none
module fpep_sticky #(
	parameter int W = 2
) (
	// clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic ce,
	// event side
	input wire logic [W-1:0] set,
	input wire logic [W-1:0] clr,
	output logic [W-1:0] q
);
	logic [W-1:0] bits_ff;
	logic [W-1:0] nxt_bits;

	// set is or-ed in after the clear so a same-cycle event survives
	always_comb begin
		nxt_bits = (bits_ff & ~clr) | set;
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			bits_ff <= '0;
		end else if (ce) begin
			bits_ff <= nxt_bits;
		end
	end

	assign q = bits_ff;
endmodule // fpep_sticky
`default_nettype wire

// >>> bench/fpep_top_monitor.sv
// checker: protection and nmi relations seen at the block ports
`default_nettype none
module fpep_top_monitor #(
	parameter int BLOCKS = 8
) (
	// clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// pins and system conditions
	input wire logic flash_write_gate_pin,
	input wire logic hard_init_pin,
	input wire logic wdt_reset,
	input wire logic sw_standby,
	input wire logic hw_standby,
	input wire logic algo_fault,
	input wire logic boot_mode,
	input wire logic boot_branch,
	input wire logic nmi_in,
	// outputs watched
	input wire logic nmi_out,
	input wire logic program_mode,
	input wire logic erase_mode,
	input wire logic verify_mode,
	input wire logic [BLOCKS-1:0] erase_block_en,
	input wire logic flash_read_undef
);
	// ==================================================================
	// one clock domain, so clock and reset are stated once
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);
	// any init condition; two cycles since the modes lag one edge
	wire logic ini = !hard_init_pin || hw_standby || wdt_reset || sw_standby;
	a_gate_low_blocks: assert property (!flash_write_gate_pin [*2] |->
		!program_mode && !erase_mode && !verify_mode) else $error("mode with gate low");
	a_init_blocks: assert property (ini [*2] |->
		!program_mode && !erase_mode && !verify_mode) else $error("mode during init");
	a_fault_aborts: assert property (algo_fault && program_mode |=>
		!program_mode && !erase_mode) else $error("fault did not abort");
	a_error_stays_shut: assert property (algo_fault && program_mode ##1
		(hard_init_pin && !hw_standby) [*6] |-> !program_mode && !erase_mode
		&& erase_block_en == '0) else $error("mode reopened in error");
	a_arm_nmi_block: assert property (flash_read_undef |-> !nmi_out)
		else $error("nmi passed while armed");
	a_nmi_cause: assert property (nmi_out |-> $past(nmi_in))
		else $error("nmi without request");
	a_boot_window: assert property (!hard_init_pin ##1
		(hard_init_pin && boot_mode && !boot_branch) [*3] |=> !nmi_out)
		else $error("nmi passed in boot window");
	a_verify_clean: assert property (verify_mode |-> $past(flash_write_gate_pin
		&& !ini)) else $error("verify under init");
	a_block_sel: assert property (erase_block_en != '0 |-> erase_mode)
		else $error("block select without erase");
endmodule // fpep_top_monitor
bind fpep_top fpep_top_monitor #(.BLOCKS(BLOCKS)) u_mon (
	.mclk(mclk),
	.reset_n(reset_n),
	.flash_write_gate_pin(flash_write_gate_pin),
	.hard_init_pin(hard_init_pin),
	.wdt_reset(wdt_reset),
	.sw_standby(sw_standby),
	.hw_standby(hw_standby),
	.algo_fault(algo_fault),
	.boot_mode(boot_mode),
	.boot_branch(boot_branch),
	.nmi_in(nmi_in),
	.nmi_out(nmi_out),
	.program_mode(program_mode),
	.erase_mode(erase_mode),
	.verify_mode(verify_mode),
	.erase_block_en(erase_block_en),
	.flash_read_undef(flash_read_undef)
);
`default_nettype wire

// >>> bench/test_fpep_top.sv
// testbench: register access, protection states and nmi gating
`default_nettype none
module test_fpep_top;
	timeunit 1ns;
	timeprecision 1ps;
	import fpep_pkg::*;
	// ==================================================================
	// stimulus and observed signals, named as the ports
	logic mclk = 1'b0, reset_n = 1'b0, ce = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
	logic [4:0] avs_address = 5'h00;
	// hard init starts low so power-on passes through the reset state
	logic [3:0] avs_byteenable = 4'hf, init_v = 4'h8;
	logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata, rq;
	logic flash_write_gate_pin = 1'b1, algo_fault = 1'b0, boot_mode = 1'b0;
	logic boot_branch = 1'b0, nmi_in = 1'b0;
	logic avs_waitrequest, nmi_out, program_mode, erase_mode, verify_mode, flash_read_undef, irq;
	logic [7:0] erase_block_en;
	int mismatches = 0, total_checks = 0, cycles = 0;
	// init conditions kept in one vector so a loop can walk them
	wire logic wdt_reset = init_v[0];
	wire logic sw_standby = init_v[1];
	wire logic hw_standby = init_v[2];
	wire logic hard_init_pin = !init_v[3];
	fpep_top DUT (
		.mclk(mclk),
		.reset_n(reset_n),
		.ce(ce),
		.avs_address(avs_address),
		.avs_read(avs_read),
		.avs_write(avs_write),
		.avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest),
		.flash_write_gate_pin(flash_write_gate_pin),
		.hard_init_pin(hard_init_pin),
		.wdt_reset(wdt_reset),
		.sw_standby(sw_standby),
		.hw_standby(hw_standby),
		.algo_fault(algo_fault),
		.boot_mode(boot_mode),
		.boot_branch(boot_branch),
		.nmi_in(nmi_in),
		.nmi_out(nmi_out),
		.program_mode(program_mode),
		.erase_mode(erase_mode),
		.verify_mode(verify_mode),
		.erase_block_en(erase_block_en),
		.flash_read_undef(flash_read_undef),
		.irq(irq)
	);
	// clock and hang guard
	initial forever #2 mclk = ~mclk;
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 4000) begin
			mismatches++;
			tally_and_finish();
		end
	end
	// ==================================================================
	// tasks; every bus call first lets an edge pass so no signal is set twice
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
	endtask
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
		@(posedge mclk);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= d;
		do @(posedge mclk); while (avs_waitrequest !== 1'b0);
		rq = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic rdchk(input logic [4:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0000_0000);
		chk(rq, exp);
	endtask
	task automatic pulse_init(input int k);
		@(posedge mclk);
		init_v <= 4'h1 << k;
		// a running hard init is held for the full minimum width
		tick(k == 3 ? 20 : 2);
		init_v <= 4'h0;
	endtask
	task automatic tally_and_finish();
		$display("checks %0d, mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// ==================================================================
	// main sequence
	initial begin
		repeat (16) @(posedge mclk);
		reset_n <= 1'b1;
		// power-on hold shortened to the running minimum to keep the run short
		tick(20);
		init_v <= 4'h0;
		rdchk(FPEP_OFS_CTRL, 32'h0000_0000);
		rdchk(FPEP_OFS_WIPE, 32'h0000_0000);
		rdchk(5'h14, 32'h0000_0000);
		nmi_in <= 1'b1;
		tick(3);
		chk(nmi_out, 32'h0000_0001);
		bus(1'b1, FPEP_OFS_WIPE, 32'h0000_005a);
		// each arm bit opens its mode and stops the nmi; only the blank arm exposes the blocks
		for (int k = 0; k < 2; k++) begin
			bus(1'b1, FPEP_OFS_CTRL, 32'h0000_0001 << k);
			tick(3);
			chk({erase_block_en, program_mode, erase_mode, flash_read_undef, nmi_out},
				k ? 32'h0000_05a6 : 32'h0000_000a);
		end
		flash_write_gate_pin <= 1'b0;
		tick(3);
		chk({program_mode, erase_mode}, 32'h0000_0000);
		rdchk(FPEP_OFS_CTRL, 32'h0000_0000);
		rdchk(FPEP_OFS_WIPE, 32'h0000_0000);
		flash_write_gate_pin <= 1'b1;
		// watchdog, software standby, hardware standby, hard init in turn
		for (int k = 0; k < 4; k++) begin
			bus(1'b1, FPEP_OFS_CTRL, 32'h0000_0001);
			pulse_init(k);
			rdchk(FPEP_OFS_CTRL, 32'h0000_0000);
		end
		rdchk(FPEP_OFS_IRQS, 32'h0000_0002);
		// fault while programming
		bus(1'b1, FPEP_OFS_IRQM, 32'h0000_0001);
		bus(1'b1, FPEP_OFS_CTRL, 32'h0000_0001);
		tick(3);
		algo_fault <= 1'b1;
		tick(1);
		algo_fault <= 1'b0;
		tick(3);
		chk({program_mode, irq}, 32'h0000_0001);
		rdchk(FPEP_OFS_CTRL, 32'h0000_0001);
		bus(1'b1, FPEP_OFS_STAT, 32'h0000_0000);
		bus(1'b0, FPEP_OFS_STAT, 32'h0000_0000);
		chk(rq[0], 32'h0000_0001);
		bus(1'b1, FPEP_OFS_CTRL, 32'h0000_0002);
		bus(1'b1, FPEP_OFS_WIPE, 32'h0000_00ff);
		tick(3);
		chk({erase_mode, program_mode, erase_block_en}, 32'h0000_0000);
		rdchk(FPEP_OFS_WIPE, 32'h0000_00ff);
		bus(1'b1, FPEP_OFS_CTRL, 32'h0000_0004);
		tick(3);
		chk({verify_mode, nmi_out}, 32'h0000_0002);
		rdchk(FPEP_OFS_IRQS, 32'h0000_0001);
		tick(2);
		chk(irq, 32'h0000_0000);
		// event interrupts masked off; a watchdog pulse leaves the error state set
		bus(1'b1, FPEP_OFS_IRQM, 32'h0000_0000);
		pulse_init(0);
		bus(1'b0, FPEP_OFS_STAT, 32'h0000_0000);
		chk(rq[0], 32'h0000_0001);
		// blank check still reaches verify in error; software standby then wipes it
		bus(1'b1, FPEP_OFS_CTRL, 32'h0000_0008);
		tick(3);
		chk(verify_mode, 32'h0000_0001);
		pulse_init(1);
		rdchk(FPEP_OFS_CTRL, 32'h0000_0000);
		pulse_init(3);
		bus(1'b0, FPEP_OFS_STAT, 32'h0000_0000);
		chk(rq[0], 32'h0000_0000);
		// boot window holds the nmi until the branch is seen
		boot_mode <= 1'b1;
		pulse_init(3);
		tick(4);
		chk(nmi_out, 32'h0000_0000);
		boot_branch <= 1'b1;
		tick(1);
		boot_branch <= 1'b0;
		tick(3);
		chk(nmi_out, 32'h0000_0001);
		bus(1'b1, FPEP_OFS_CTRL, 32'h0000_0001);
		tick(3);
		chk(nmi_out, 32'h0000_0000);
		tally_and_finish();
	end
endmodule // test_fpep_top
`default_nettype wire
